/* dv/rsc_regs_chk.sv */
`timescale 1ns/100ps
`include "rsc_map.vh"

module rsc_regs_chk (
   input wire       clock,               // clock
   input wire       rstn,                // reset, active low
   input wire [6:0] fifoByteCount,       // fifo fill
   input wire [5:0] extAddr,             // external address
   input wire       extWrite,            // external write pulse
   input wire       strobeValid,         // strobe pulse
   input wire [5:0] strobeCode,          // strobe address
   input wire [5:0] pinASignalSelect,    // pin a select
   input wire [5:0] pinBSignalSelect,    // pin b select
   input wire       outputPinAOeN,       // pin a enable, low
   input wire       outputPinB,          // pin b level
   input wire       outputPinBOeN,       // pin b enable, low
   input wire       outputDriveStrength, // drive strength
   input wire       tempSensorEnable,    // sensor on
   input wire       thresholdExceeded    // threshold flag
);
   localparam logic [15:0] STROBES = `RSC_STROBE_MASK;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   property p_reset_vals;
      $rose(rstn) |-> pinBSignalSelect == 6'h2E && pinASignalSelect == 6'h3F
         && !outputDriveStrength && !tempSensorEnable;
   endproperty
   a_reset_vals: assert property (p_reset_vals)
      else $error("field reset values wrong");
   property p_strobe;
      strobeValid |-> (strobeCode >= 6'h30 && strobeCode <= 6'h3D
         && STROBES[strobeCode[3:0]]) ##1 !strobeValid;
   endproperty
   a_strobe: assert property (p_strobe) else $error("bad strobe pulse");
   property p_ext_write;
      extWrite |-> !(extAddr inside {6'h01, 6'h02, 6'h03})
         && (extAddr <= 6'h2E || extAddr >= 6'h3E) ##1 !extWrite;
   endproperty
   a_ext_write: assert property (p_ext_write) else $error("bad external write");
   property p_thr_full;
      (fifoByteCount >= 7'h3D) [*2] |-> thresholdExceeded;
   endproperty
   a_thr_full: assert property (p_thr_full) else $error("flag low at full");
   property p_thr_empty;
      (fifoByteCount == 7'h00) [*2] |-> !thresholdExceeded;
   endproperty
   a_thr_empty: assert property (p_thr_empty) else $error("flag high when empty");
   property p_tri_b;
      (pinBSignalSelect == 6'h2E) [*3] |-> outputPinBOeN;
   endproperty
   a_tri_b: assert property (p_tri_b) else $error("pin b driven in tri-state");
   property p_temp_tri;
      tempSensorEnable [*3] |-> outputPinAOeN;
   endproperty
   a_temp_tri: assert property (p_temp_tri) else $error("pin a driven with sensor");
   property p_thr_route;
      $changed(thresholdExceeded) && pinBSignalSelect == 6'h02 && $stable(pinBSignalSelect)
         |=> $changed(outputPinB) && !outputPinBOeN;
   endproperty
   a_thr_route: assert property (p_thr_route) else $error("flag not on pin b");
endmodule

bind rsc_spi_config_regs rsc_regs_chk u_chk (
   .clock, .rstn, .fifoByteCount, .extAddr, .extWrite, .strobeValid, .strobeCode,
   .pinASignalSelect, .pinBSignalSelect, .outputPinAOeN, .outputPinB, .outputPinBOeN,
   .outputDriveStrength, .tempSensorEnable, .thresholdExceeded
);

/* dv/rsc_spi_config_regs_tb.sv */
`timescale 1ns/100ps
`include "rsc_map.vh"

module rsc_spi_config_regs_tb;
   localparam logic [15:0] STROBES = `RSC_STROBE_MASK;
   logic        clock = 1'b0, rstn = 1'b0, idleBit = 1'b0, pinASignal = 1'b0, pinBSignal = 1'b0;
   logic [7:0]  chipStatus = 8'hA5, lastExtData, hdrRx;
   logic [6:0]  fifoByteCount = 7'h00;
   logic [5:0]  lastStrobe, lastExtAddr;
   logic [6:0]  lvl [16] = '{7'h3D, 7'h39, 7'h35, 7'h31, 7'h2D, 7'h29, 7'h25, 7'h21,
                             7'h1D, 7'h19, 7'h15, 7'h11, 7'h0D, 7'h09, 7'h05, 7'h01};
   logic [15:0] rdRows [5] = '{16'h8700, 16'hF400, 16'hF5B5, 16'h8484, 16'hC700};
   int          nFail = 0, checked = 0, nStrobe = 0;
   wire         csn, sclk, mosi, miso, misoOeN, misoLine, extWrite, strobeValid, outputPinA;
   wire         outputPinAOeN, outputPinB, outputPinBOeN, outputDriveStrength;
   wire         tempSensorEnable, thresholdExceeded;
   wire  [5:0]  extAddr, strobeCode, pinASignalSelect, pinBSignalSelect;
   wire  [7:0]  extReadData, extWriteData;

   always #10 clock = ~clock;
   always @(posedge clock) idleBit <= ~idleBit;
   assign misoLine = misoOeN ? idleBit : miso;
   assign extReadData = {2'b10, extAddr};
   always @(posedge clock) begin
      if (strobeValid === 1'b1) begin
         nStrobe++;
         lastStrobe = strobeCode;
      end
      if (extWrite === 1'b1) begin
         lastExtAddr = extAddr;
         lastExtData = extWriteData;
      end
   end

   rsc_spi_config_regs u_dut (
      .clock, .rstn, .csn, .sclk, .mosi, .miso, .misoOeN, .chipStatus, .fifoByteCount,
      .extAddr, .extReadData, .extWrite, .extWriteData, .strobeValid, .strobeCode,
      .pinASignal, .pinBSignal, .pinASignalSelect, .pinBSignalSelect, .outputPinA,
      .outputPinAOeN, .outputPinB, .outputPinBOeN, .outputDriveStrength,
      .tempSensorEnable, .thresholdExceeded);
   rsc_spi_host u_host (.clock, .csn, .sclk, .mosi, .miso(misoLine));

   // ***********************************************
   // tasks
   // ***********************************************
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         nFail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic frame(input logic [7:0] hdr, input int n, input logic [31:0] tx,
                        output logic [31:0] rx);
      logic [7:0] b;
      rx = 32'h0000_0000;
      u_host.start();
      u_host.xfer(hdr, hdrRx);
      for (int i = 0; i < n; i++) begin
         u_host.xfer(tx[31-8*i -: 8], b);
         rx[31-8*i -: 8] = b;
      end
      u_host.stop();
   endtask
   task automatic wr(input logic [7:0] hdr, input logic [7:0] d);
      logic [31:0] r;
      frame(hdr, 1, {d, 24'h00_0000}, r);
      chk("statusHdr", chipStatus, hdrRx);
      chk("statusWr", chipStatus, r[31:24]);
      u_host.tick(6);
   endtask
   task automatic rdChk(input logic [7:0] hdr, input logic [7:0] exp, input string what);
      logic [31:0] r;
      frame(hdr, 1, 32'h0000_0000, r);
      chk(what, exp, r[31:24]);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", checked, nFail);
      if (nFail == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ***********************************************
   // tests
   // ***********************************************
   initial begin
      #1_000_000;
      nFail++;
      $display("watchdog expired");
      tally_and_finish();
   end

   initial begin
      int t;
      logic [31:0] r;
      repeat (6) @(posedge clock);
      #1 rstn = 1'b1;
      u_host.tick(6);
      for (int s = 0; s < 16; s++) begin
         chipStatus = {~s[3:0], s[3:0]};
         wr(8'h03, s[7:0]);
         fifoByteCount = lvl[s];
         u_host.tick(2);
         chk("thrAt", 8'h01, {7'h00, thresholdExceeded});
         fifoByteCount = lvl[s] - 7'h01;
         u_host.tick(2);
         chk("thrBelow", 8'h00, {7'h00, thresholdExceeded});
      end
      $display("test threshold table done");
      rdChk(8'h83, 8'h0F, "thrRead");
      frame(8'h30, 0, 32'h0000_0000, r);
      u_host.tick(6);
      chk("pinBSel", 8'h2E, {2'b00, pinBSignalSelect});
      chk("pinASel", 8'h3F, {2'b00, pinASignalSelect});
      chk("pinBOff", 8'h01, {7'h00, outputPinBOeN});
      chk("drive", 8'h00, {7'h00, outputDriveStrength});
      chk("sensor", 8'h00, {7'h00, tempSensorEnable});
      rdChk(8'h83, 8'h07, "thrReset");
      r[0] = outputPinA;
      for (t = 0; t < 300 && outputPinA === r[0]; t++) u_host.tick(1);
      r[0] = outputPinA;
      for (t = 0; t < 300 && outputPinA === r[0]; t++) u_host.tick(1);
      chk("clkHalf", 8'h60, t[7:0]);
      rdChk(8'h81, 8'h2E, "pinBReset");
      rdChk(8'h82, 8'h3F, "pinAReset");
      wr(8'h02, 8'h2E);
      chk("pinAOff", 8'h01, {7'h00, outputPinAOeN});
      $display("test reset state done");
      fifoByteCount = 7'h00;
      wr(8'h01, 8'h42);
      chk("pinBInv", 8'h01, {6'h00, outputPinBOeN, outputPinB});
      fifoByteCount = 7'h21;
      u_host.tick(6);
      chk("pinBThr", 8'h00, {7'h00, outputPinB});
      pinBSignal = 1'b1;
      wr(8'h01, 8'h80);
      chk("pinBExt", 8'h03, {6'h00, outputDriveStrength, outputPinB});
      pinASignal = 1'b1;
      wr(8'h02, 8'h40);
      chk("pinAInv", 8'h00, {7'h00, outputPinA});
      wr(8'h02, 8'h80);
      chk("sensorOn", 8'h03, {6'h00, tempSensorEnable, outputPinAOeN});
      $display("test pins done");
      frame(8'h41, 4, 32'h072E_0A5A, r);
      chk("burstAddr", 8'h04, {2'b00, lastExtAddr});
      chk("burstData", 8'h5A, lastExtData);
      frame(8'hC1, 4, 32'h0000_0000, r);
      for (int i = 0; i < 4; i++)
         chk("burstRead", 8'(32'h072E_0A84 >> (24 - 8*i)), r[31-8*i -: 8]);
      t = nStrobe;
      foreach (rdRows[i]) rdChk(rdRows[i][15:8], rdRows[i][7:0], "mapRead");
      t = nStrobe - t;
      chk("statusNoStrobe", 8'h00, t[7:0]);
      $display("test address map done");
      for (int c = 48; c < 62; c++) begin
         t = nStrobe;
         frame({c[0], 1'b0, c[5:0]}, 0, 32'h0000_0000, r);
         t = nStrobe - t;
         chk("strobeCount", {7'h00, STROBES[c-48]}, t[7:0]);
         if (STROBES[c-48])
            chk("strobeCode", {2'b00, c[5:0]}, {2'b00, lastStrobe});
      end
      rdChk(8'h81, 8'h2E, "pinBAfter");
      $display("test strobes done");
      tally_and_finish();
   end
endmodule

/* dv/rsc_spi_host.sv */
`timescale 1ns/100ps

module rsc_spi_host (
   input  wire  clock, // paces bit times
   output logic csn,   // select, active low
   output logic sclk,  // spi clock, idle low
   output logic mosi,  // data to device
   input  wire  miso   // data from device
);
   initial begin
      csn = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic start();
      csn = 1'b0;
      tick(6);
   endtask
   // msb first, miso taken at the rise
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         mosi = tx[i];
         tick(6);
         sclk = 1'b1;
         rx[i] = miso;
         tick(6);
         sclk = 1'b0;
      end
   endtask
   // released data line flips so no stale level looks valid
   task automatic stop();
      tick(6);
      csn = 1'b1;
      mosi = ~mosi;
      tick(8);
   endtask
endmodule

/* hdl/rsc_pin_sync.v */
`timescale 1ns/100ps

module rsc_pin_sync #(
   parameter             WIDTH       = 1,
   parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
   input  wire             clock,   // system clock
   input  wire             rstn,    // async reset, active low
   input  wire [WIDTH-1:0] pinIn,   // raw pin levels
   output reg  [WIDTH-1:0] pinOut   // filtered level
);

   reg [WIDTH-1:0] stage1_reg;
   reg [WIDTH-1:0] stage2_reg;
   reg [WIDTH-1:0] stage3_reg;
   integer         i;

   // ***************************************************************
   // three stages, change accepted once stages two and three agree
   // ***************************************************************
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         stage1_reg <= RESET_VALUE;
         stage2_reg <= RESET_VALUE;
         stage3_reg <= RESET_VALUE;
         pinOut     <= RESET_VALUE;
      end else begin
         stage1_reg <= pinIn;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
         for (i = 0; i < WIDTH; i = i + 1) begin
            if (stage2_reg[i] == stage3_reg[i]) begin
               pinOut[i] <= stage3_reg[i];
            end
         end
      end
   end

endmodule

/* hdl/rsc_spi_config_regs.v */
`timescale 1ns/100ps
`include "rsc_map.vh"

module rsc_spi_config_regs (
   input  wire       clock,                // 50 MHz crystal clock
   input  wire       rstn,                 // async reset, active low
   input  wire       csn,                  // spi chip select pin, active low
   input  wire       sclk,                 // spi clock pin
   input  wire       mosi,                 // spi data in pin
   output wire       miso,                 // spi data out pin
   output wire       misoOeN,              // miso drive enable, active low
   input  wire [7:0] chipStatus,           // status byte from radio control
   input  wire [6:0] fifoByteCount,        // bytes held in transmit fifo
   output reg  [5:0] extAddr,              // address of external access
   input  wire [7:0] extReadData,          // data of external register at extAddr
   output reg        extWrite,             // external write pulse
   output reg  [7:0] extWriteData,         // external write data
   output reg        strobeValid,          // command strobe pulse
   output reg  [5:0] strobeCode,           // command strobe address
   input  wire       pinASignal,           // signal picked by outside table, pin a
   input  wire       pinBSignal,           // signal picked by outside table, pin b
   output wire [5:0] pinASignalSelect,     // pin a select field
   output wire [5:0] pinBSignalSelect,     // pin b select field
   output reg        outputPinA,           // pin a level
   output reg        outputPinAOeN,        // pin a drive enable, active low
   output reg        outputPinB,           // pin b level
   output reg        outputPinBOeN,        // pin b drive enable, active low
   output wire       outputDriveStrength,  // 1 high drive, 0 low drive
   output wire       tempSensorEnable,     // analog temperature sensor on
   output reg        thresholdExceeded     // transmit fifo at or above threshold
);

   // ***************************************************************
   // pin sampling
   // ***************************************************************
   wire csnS;
   wire sclkS;
   wire mosiS;

   rsc_pin_sync #(
      .WIDTH       (3),
      .RESET_VALUE (3'b100)
   ) uPinSync (
      .clock  (clock),
      .rstn   (rstn),
      .pinIn  ({csn, sclk, mosi}),
      .pinOut ({csnS, sclkS, mosiS})
   );

   // ***************************************************************
   // state
   // ***************************************************************
   reg  [7:0] pinBCfg_reg;
   reg  [7:0] pinACfg_reg;
   reg  [7:0] thrCfg_reg;
   reg  [6:0] shiftIn_reg;
   reg  [6:0] shiftOut_reg;
   reg  [2:0] bitCnt_reg;
   reg        miso_reg;
   reg  [7:0] txByte_reg;
   reg  [5:0] addr_reg;
   reg        isRead_reg;
   reg        isBurst_reg;
   reg        inHeader_reg;
   reg        loadPending_reg;
   reg        sclkD_reg;
   reg        csnD_reg;
   reg  [6:0] divCnt_reg;
   reg        divClk_reg;
   reg  [7:0] readData;

   wire       sclkRise = sclkS & ~sclkD_reg & ~csnS;
   wire       sclkFall = ~sclkS & sclkD_reg & ~csnS;
   wire       csnFall  = ~csnS & csnD_reg;
   wire       byteDone = sclkRise & (bitCnt_reg == 3'h7);
   wire [7:0] rxByte   = {shiftIn_reg, mosiS};

   wire [5:0] hdrAddr   = rxByte[`RSC_HDR_ADDR_MSB:0];
   wire       hdrRead   = rxByte[`RSC_HDR_READ_BIT];
   wire       hdrBurst  = rxByte[`RSC_HDR_BURST_BIT];
   wire       hdrHigh   = (hdrAddr >= `RSC_STROBE_BASE);
   wire       hdrMulti  = (hdrAddr >= `RSC_ADDR_PATABLE);
   wire       hdrStrobe = hdrHigh & ~hdrMulti & ~hdrBurst;
   wire [15:0] strobeMask = `RSC_STROBE_MASK;
   wire [15:0] statusMask = `RSC_STATUS_MASK;
   wire [47:0] cfgMask    = `RSC_CFG_IMPL_MASK;

   wire       addrCfg   = (addr_reg < `RSC_STROBE_BASE);
   wire       addrMulti = (addr_reg >= `RSC_ADDR_PATABLE);
   wire       cfgExists = addrCfg & (addr_reg <= `RSC_CFG_LAST) & cfgMask[addr_reg];
   wire       stayData  = isBurst_reg & (addrCfg | addrMulti);

   // ***************************************************************
   // read data select
   // ***************************************************************
   always @* begin
      readData = 8'h00;
      if (addr_reg == `RSC_ADDR_PIN_B) begin
         readData = pinBCfg_reg;
      end else if (addr_reg == `RSC_ADDR_PIN_A) begin
         readData = pinACfg_reg;
      end else if (addr_reg == `RSC_ADDR_THR) begin
         readData = thrCfg_reg;
      end else if (cfgExists) begin
         readData = extReadData;
      end else if (addr_reg == `RSC_ADDR_PATABLE) begin
         readData = extReadData;
      end else if (!addrCfg && !addrMulti && isBurst_reg &&
                   statusMask[addr_reg[3:0]]) begin
         readData = extReadData;
      end
   end

   // ***************************************************************
   // spi byte engine and register writes
   // ***************************************************************
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pinBCfg_reg     <= `RSC_PIN_B_RESET;
         pinACfg_reg     <= `RSC_PIN_A_RESET;
         thrCfg_reg      <= `RSC_THR_RESET;
         shiftIn_reg     <= 7'h00;
         shiftOut_reg    <= 7'h00;
         bitCnt_reg      <= 3'h0;
         miso_reg        <= 1'b0;
         txByte_reg      <= 8'h00;
         addr_reg        <= 6'h00;
         isRead_reg      <= 1'b0;
         isBurst_reg     <= 1'b0;
         inHeader_reg    <= 1'b1;
         loadPending_reg <= 1'b0;
         sclkD_reg       <= 1'b0;
         csnD_reg        <= 1'b1;
         extAddr         <= 6'h00;
         extWrite        <= 1'b0;
         extWriteData    <= 8'h00;
         strobeValid     <= 1'b0;
         strobeCode      <= 6'h00;
      end else begin
         sclkD_reg   <= sclkS;
         csnD_reg    <= csnS;
         extWrite    <= 1'b0;
         strobeValid <= 1'b0;
         if (loadPending_reg) begin
            txByte_reg      <= readData;
            loadPending_reg <= 1'b0;
         end
         if (csnS) begin
            bitCnt_reg   <= 3'h0;
            inHeader_reg <= 1'b1;
         end else begin
            if (csnFall) begin
               miso_reg     <= chipStatus[7];
               shiftOut_reg <= chipStatus[6:0];
            end
            if (sclkFall) begin
               if (bitCnt_reg == 3'h0) begin
                  miso_reg     <= txByte_reg[7];
                  shiftOut_reg <= txByte_reg[6:0];
               end else begin
                  miso_reg     <= shiftOut_reg[6];
                  shiftOut_reg <= {shiftOut_reg[5:0], 1'b0};
               end
            end
            if (sclkRise) begin
               shiftIn_reg <= rxByte[6:0];
               bitCnt_reg  <= bitCnt_reg + 3'h1;
            end
            if (byteDone && inHeader_reg) begin
               addr_reg    <= hdrAddr;
               isRead_reg  <= hdrRead;
               isBurst_reg <= hdrBurst;
               txByte_reg  <= chipStatus;
               if (hdrStrobe) begin
                  if (strobeMask[hdrAddr[3:0]]) begin
                     strobeValid <= 1'b1;
                     strobeCode  <= hdrAddr;
                  end
                  if (hdrAddr == `RSC_STROBE_RESET) begin
                     pinBCfg_reg <= `RSC_PIN_B_RESET;
                     pinACfg_reg <= `RSC_PIN_A_RESET;
                     thrCfg_reg  <= `RSC_THR_RESET;
                  end
               end else begin
                  inHeader_reg    <= 1'b0;
                  loadPending_reg <= hdrRead;
                  extAddr         <= hdrAddr;
               end
            end else if (byteDone) begin
               if (!isRead_reg) begin
                  if (addr_reg == `RSC_ADDR_PIN_B) begin
                     pinBCfg_reg <= rxByte;
                  end else if (addr_reg == `RSC_ADDR_PIN_A) begin
                     pinACfg_reg <= rxByte;
                  end else if (addr_reg == `RSC_ADDR_THR) begin
                     thrCfg_reg <= rxByte;
                  end else if (cfgExists || addrMulti) begin
                     extWrite     <= 1'b1;
                     extAddr      <= addr_reg;
                     extWriteData <= rxByte;
                  end
               end
               txByte_reg <= chipStatus;
               if (stayData) begin
                  if (addrCfg) begin
                     addr_reg <= addr_reg + 6'h01;
                     if (isRead_reg) begin
                        // next address goes out now so its data is there at the load
                        extAddr <= addr_reg + 6'h01;
                     end
                  end
                  loadPending_reg <= isRead_reg;
               end else begin
                  inHeader_reg <= 1'b1;
               end
            end
         end
      end
   end

   assign miso    = miso_reg;
   assign misoOeN = csnS;

   // ***************************************************************
   // crystal divide-by-192 clock output source
   // ***************************************************************
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         divCnt_reg <= 7'h00;
         divClk_reg <= 1'b0;
      end else if (divCnt_reg == `RSC_XOSC_HALF_M1) begin
         divCnt_reg <= 7'h00;
         divClk_reg <= ~divClk_reg;
      end else begin
         divCnt_reg <= divCnt_reg + 7'h01;
      end
   end

   // ***************************************************************
   // threshold and output pins
   // ***************************************************************
   wire [6:0] thrBytes = `RSC_THR_BASE - {1'b0, thrCfg_reg[`RSC_THR_MSB:0], 2'b00};

   function pinSource;
      input [5:0] sel;
      input       ext;
      input       thr;
      input       div;
      begin
         if (sel == `RSC_SEL_XOSC_DIV) begin
            pinSource = div;
         end else if (sel == `RSC_SEL_THRESHOLD) begin
            pinSource = thr;
         end else begin
            pinSource = ext;
         end
      end
   endfunction

   assign pinASignalSelect    = pinACfg_reg[`RSC_SEL_MSB:0];
   assign pinBSignalSelect    = pinBCfg_reg[`RSC_SEL_MSB:0];
   assign outputDriveStrength = pinBCfg_reg[`RSC_DRIVE_BIT];
   assign tempSensorEnable    = pinACfg_reg[`RSC_TEMP_BIT];

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         thresholdExceeded <= 1'b0;
         outputPinA        <= 1'b0;
         outputPinAOeN     <= 1'b0;
         outputPinB        <= 1'b0;
         outputPinBOeN     <= 1'b1;
      end else begin
         thresholdExceeded <= (fifoByteCount >= thrBytes);
         outputPinA    <= pinSource(pinASignalSelect, pinASignal, thresholdExceeded,
                                    divClk_reg) ^ pinACfg_reg[`RSC_INV_BIT];
         // analog sensor output takes pin a, so the digital driver lets go
         outputPinAOeN <= (pinASignalSelect == `RSC_SEL_TRISTATE) | tempSensorEnable;
         outputPinB    <= pinSource(pinBSignalSelect, pinBSignal, thresholdExceeded,
                                    divClk_reg) ^ pinBCfg_reg[`RSC_INV_BIT];
         outputPinBOeN <= (pinBSignalSelect == `RSC_SEL_TRISTATE);
      end
   end

endmodule

/* pkg/rsc_map.vh */
`ifndef RSC_MAP_VH
`define RSC_MAP_VH

// ***************************************************************
// header byte layout
// ***************************************************************
`define RSC_HDR_READ_BIT   7
`define RSC_HDR_BURST_BIT  6
`define RSC_HDR_ADDR_MSB   5

// ***************************************************************
// address space
// ***************************************************************
`define RSC_ADDR_PIN_B     6'h01
`define RSC_ADDR_PIN_A     6'h02
`define RSC_ADDR_THR       6'h03
`define RSC_CFG_LAST       6'h2E
`define RSC_STROBE_BASE    6'h30
`define RSC_STROBE_RESET   6'h30
`define RSC_ADDR_PATABLE   6'h3E
`define RSC_ADDR_FIFO      6'h3F
// bit n set: configuration address n exists on this device
`define RSC_CFG_IMPL_MASK  48'h767C_01BF_E77E
// bit n set: status register at 0x30+n exists (burst read)
`define RSC_STATUS_MASK    16'h0723
// bit n set: command strobe at 0x30+n exists
`define RSC_STROBE_MASK    16'h2A6F

// ***************************************************************
// reset values
// ***************************************************************
`define RSC_PIN_B_RESET    8'h2E
`define RSC_PIN_A_RESET    8'h3F
`define RSC_THR_RESET      8'h07

// ***************************************************************
// field positions
// ***************************************************************
`define RSC_DRIVE_BIT      7
`define RSC_TEMP_BIT       7
`define RSC_INV_BIT        6
`define RSC_SEL_MSB        5
`define RSC_THR_MSB        3

// ***************************************************************
// signal select codes and threshold mapping
// ***************************************************************
`define RSC_SEL_TRISTATE   6'h2E
`define RSC_SEL_XOSC_DIV   6'h3F
`define RSC_SEL_THRESHOLD  6'h02
`define RSC_THR_BASE       7'h3D

// ***************************************************************
// timing counts
// ***************************************************************
`define RSC_XOSC_DIV       192
`define RSC_XOSC_HALF_M1   7'h5F

`endif
